//--- design/sep_core.sv
// serial eeprom command decoder, protect pointer and self-timed programming
// Notes on behaviour
// - an instruction is a one start bit, two opcode bits, six address bits, then data.
// - a stopped serial clock leaves all state intact; shifting resumes on the next edge.
// - the array is 64 words of 16 bits, picked by a six-bit address.
// - a read loads the word into a 16-bit shifter, sending one zero first.
// - read data on the output changes only on rising serial clock edges.
// - array reads continue at ascending addresses, wrapping to zero, until chip select drops.
// - power-up is write-disabled; enable and disable commands switch it.
// - enable and disable commands never affect reads.
// - chip select falling after a full programming command starts an erase-then-write cycle.
// - word write needs write enable, program pin high while loading, address below pointer unless the pointer is cleared.
// - with chip select high after the start, output shows low busy, high ready.
// - chip select high, input high and a rising clock edge clear the status.
// - global write fills every word only with pointer cleared and program pin high.
// - write disable blocks all programming until the next write enable.
// - protect select low: 10 read, 01 word write, 11 word erase.
// - protect select low, opcode 00: 11 enable, 01 global write, 00 disable.
// - protect select low, opcode 00 with 10: global erase, program pin high.
// - protect select high: read pointer, arm, clear, write, freeze pointer.
// - the pointer holds the lowest protected address and can be frozen until the next reset.
// - freezing works once; afterwards every pointer change is refused.
// - erases set bits to one and skip protected words.
// - pointer read sends a zero then the address; cleared pointer reads all ones.
`timescale 1ns/1ps

module sep_core #(
  parameter int unsigned PROG_TIME_NS = 2000000
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  input  wire logic i_serial_clock_pin,
  input  wire logic i_chip_select,
  input  wire logic i_serial_in_pin,
  input  wire logic i_program_enable_pin,
  input  wire logic i_protect_select_pin,
  output logic      o_serial_out,
  output logic      o_serial_out_en
);
  import sep_pkg::*;

  // programming time is a least time, so it rounds up
  localparam int unsigned PROG_CYC_I = (PROG_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYC_I - 1);

  // a word may change only below the pointer, unless it was cleared
  function automatic logic unprot(input logic [5:0] a, input logic [5:0] p, input logic clr);
    unprot = clr | (a < p);
  endfunction : unprot

  // the value shifted out by a pointer read
  function automatic logic [5:0] ptr_view(input logic [5:0] p, input logic clr);
    ptr_view = clr ? PTR_RST : p;
  endfunction : ptr_view

  sep_link_type lq, l_nxt;
  sep_cmd_type  cq, c_nxt;
  sep_core_type q, q_nxt;
  logic         link_rst_b;
  logic         done_ev;

  // chip select low holds the shifter cleared with no clock edge needed
  assign link_rst_b = i_rst_b & i_chip_select;

  // serial-side receiver and read shifter
  always_comb
  begin
    l_nxt   = lq;
    done_ev = 1'b0;
    case (lq.st)
      LS_IDLE:
      begin
        if (i_serial_in_pin)
        begin
          l_nxt.st    = LS_HDR;
          l_nxt.cnt   = '0;
          l_nxt.prog_ok = i_program_enable_pin;
          l_nxt.pre   = i_protect_select_pin;
        end
      end
      LS_HDR:
      begin
        l_nxt.hdr   = {lq.hdr[HDR_W-2:0], i_serial_in_pin};
        l_nxt.prog_ok = lq.prog_ok & i_program_enable_pin;
        l_nxt.cnt   = BIT_CNT_W'(lq.cnt + 1'b1);
        if (lq.cnt == 4'h7)
        begin
          l_nxt.cnt = '0;
          if (l_nxt.hdr[7:6] == OP_READ)
          begin
            // dummy zero goes out on this very edge
            l_nxt.st   = LS_READ;
            l_nxt.dout = 1'b0;
            l_nxt.addr = l_nxt.hdr[5:0];
            l_nxt.osr  = lq.pre ? {ptr_view(q.ptr, q.ptr_clr), 10'h000} : q.mem[l_nxt.hdr[5:0]];
          end
          else if (!lq.pre && (l_nxt.hdr[7:6] == OP_WRITE ||
                   (l_nxt.hdr[7:6] == OP_SPECIAL && l_nxt.hdr[5:4] == SUB_GLOB_WR)))
          begin
            l_nxt.st = LS_DATA;
          end
          else
          begin
            l_nxt.st = LS_DONE;
            done_ev  = 1'b1;
          end
        end
      end
      LS_DATA:
      begin
        l_nxt.dat   = {lq.dat[WORD_W-2:0], i_serial_in_pin};
        l_nxt.prog_ok = lq.prog_ok & i_program_enable_pin;
        l_nxt.cnt   = BIT_CNT_W'(lq.cnt + 1'b1);
        if (lq.cnt == 4'hf)
        begin
          l_nxt.st = LS_DONE;
          done_ev  = 1'b1;
        end
      end
      LS_READ:
      begin
        l_nxt.dout = lq.osr[WORD_W-1];
        l_nxt.osr  = {lq.osr[WORD_W-2:0], 1'b0};
        l_nxt.cnt  = BIT_CNT_W'(lq.cnt + 1'b1);
        if (lq.cnt == 4'hf)
        begin
          // next word follows with no second dummy bit; pointer reads repeat
          if (lq.pre)
          begin
            l_nxt.osr = {ptr_view(q.ptr, q.ptr_clr), 10'h000};
          end
          else
          begin
            l_nxt.addr = ADDR_W'(lq.addr + 1'b1);
            l_nxt.osr  = q.mem[l_nxt.addr];
          end
        end
      end
      LS_DONE:
      begin
        l_nxt = lq; // extra clocks after a complete command are ignored
      end
      default:
      begin
        l_nxt.st = LS_IDLE;
      end
    endcase
  end

  // edge-only shifter: nothing moves while the serial clock stands still
  always_ff @(posedge i_serial_clock_pin or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      lq <= '{st: LS_IDLE, default: '0};
    end
    else
    begin
      lq <= l_nxt;
    end
  end

  // hand-off record: fields load on the same edge that flips the toggle
  always_comb
  begin
    c_nxt = cq;
    if (done_ev)
    begin
      c_nxt.op      = l_nxt.hdr[7:6];
      c_nxt.addr    = l_nxt.hdr[5:0];
      c_nxt.data    = l_nxt.dat;
      c_nxt.prog_ok = l_nxt.prog_ok;
      c_nxt.pre     = lq.pre;
      c_nxt.cmd_tgl = ~cq.cmd_tgl;
    end
    if (i_chip_select && i_serial_in_pin && lq.st == LS_IDLE)
    begin
      c_nxt.clr_tgl = ~cq.clr_tgl;
    end
  end

  // not cleared by chip select, or the command would vanish as it is issued
  always_ff @(posedge i_serial_clock_pin or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cq <= '0;
    end
    else
    begin
      cq <= c_nxt;
    end
  end

  // reference side: synchronisers, command execution, programming timer
  always_comb
  begin
    q_nxt        = q;
    q_nxt.cs_s1  = i_chip_select;
    q_nxt.cs_s2  = q.cs_s1;
    q_nxt.tgl_s1 = cq.cmd_tgl;
    q_nxt.tgl_s2 = q.tgl_s1;
    q_nxt.clr_s1 = cq.clr_tgl;
    q_nxt.clr_s2 = q.clr_s1;

    // self-timed cycle
    if (q.busy)
    begin
      q_nxt.pcnt = PROG_CNT_W'(q.pcnt + 1'b1);
      if (q.pcnt == PROG_LAST)
      begin
        q_nxt.busy = 1'b0;
        q_nxt.pcnt = '0;
      end
    end

    // status clear first, so a cycle starting in the same clock wins
    if (q.clr_s2 != q.clr_seen)
    begin
      q_nxt.clr_seen = q.clr_s2;
      q_nxt.vis      = 1'b0;
    end

    // a complete command executes once chip select is seen low
    if (q.tgl_s2 != q.tgl_seen && !q.cs_s2)
    begin
      q_nxt.tgl_seen = q.tgl_s2;
      if (!q.busy)
      begin
        q_nxt.armed = 1'b0;
        if (!cq.pre)
        begin
          case (cq.op)
            OP_WRITE:
            begin
              if (q.wen && cq.prog_ok && unprot(cq.addr, q.ptr, q.ptr_clr))
              begin
                q_nxt.mem[cq.addr] = cq.data;
                q_nxt.busy         = 1'b1;
                q_nxt.vis          = 1'b1;
              end
            end
            OP_ERASE:
            begin
              if (q.wen && cq.prog_ok && unprot(cq.addr, q.ptr, q.ptr_clr))
              begin
                q_nxt.mem[cq.addr] = WORD_RST;
                q_nxt.busy         = 1'b1;
                q_nxt.vis          = 1'b1;
              end
            end
            OP_SPECIAL:
            begin
              case (cq.addr[5:4])
                SUB_ENABLE:  q_nxt.wen = 1'b1;
                SUB_DISABLE: q_nxt.wen = 1'b0;
                SUB_GLOB_WR:
                begin
                  if (q.wen && cq.prog_ok && q.ptr_clr)
                  begin
                    for (int i = 0; i < WORDS; i++)
                    begin
                      q_nxt.mem[i] = cq.data;
                    end
                    q_nxt.busy = 1'b1;
                    q_nxt.vis  = 1'b1;
                  end
                end
                default:
                begin
                  if (q.wen && cq.prog_ok)
                  begin
                    for (int i = 0; i < WORDS; i++)
                    begin
                      if (unprot(ADDR_W'(i), q.ptr, q.ptr_clr))
                      begin
                        q_nxt.mem[i] = WORD_RST;
                      end
                    end
                    q_nxt.busy = 1'b1;
                    q_nxt.vis  = 1'b1;
                  end
                end
              endcase
            end
            default:
            begin
              q_nxt.armed = 1'b0; // reads change nothing here
            end
          endcase
        end
        else
        begin
          // protect pointer commands need write enable and the pin; all but arm need arming too
          case (cq.op)
            OP_SPECIAL:
            begin
              if (cq.addr[5:4] == SUB_ENABLE)
              begin
                q_nxt.armed = q.wen & cq.prog_ok;
              end
              else if (cq.addr == PR_FREEZE_ADDR && q.armed && q.wen && cq.prog_ok && !q.frozen)
              begin
                q_nxt.frozen = 1'b1;
                q_nxt.busy   = 1'b1;
                q_nxt.vis    = 1'b1;
              end
            end
            OP_ERASE:
            begin
              if (cq.addr == PR_CLEAR_ADDR && q.armed && q.wen && cq.prog_ok && !q.frozen)
              begin
                q_nxt.ptr_clr = 1'b1;
                q_nxt.ptr     = PTR_RST;
                q_nxt.busy    = 1'b1;
                q_nxt.vis     = 1'b1;
              end
            end
            OP_WRITE:
            begin
              if (q.armed && q.wen && cq.prog_ok && !q.frozen && q.ptr_clr)
              begin
                q_nxt.ptr     = cq.addr;
                q_nxt.ptr_clr = 1'b0;
                q_nxt.busy    = 1'b1;
                q_nxt.vis     = 1'b1;
              end
            end
            default:
            begin
              q_nxt.armed = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // reference-domain registers; array powers up erased and unprotected
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      q         <= '0;
      q.mem     <= {WORDS{WORD_RST}};
      q.ptr     <= PTR_RST;
      q.ptr_clr <= PTR_CLR_RST;
      q.wen     <= 1'b0;
    end
    else
    begin
      q <= q_nxt;
    end
  end

  // output: read data while reading, otherwise status once a cycle has begun
  always_comb
  begin
    o_serial_out_en = i_chip_select & ((lq.st == LS_READ) | q.vis);
    if (lq.st == LS_READ)
    begin
      o_serial_out = lq.dout;
    end
    else
    begin
      o_serial_out = ~q.busy;
    end
  end

endmodule : sep_core

//--- shared/sep_pkg.sv
// shared constants, types and state records of the serial eeprom command block
package sep_pkg;

  // array geometry
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned WORDS         = 64;
  localparam int unsigned HDR_W         = 8;     // opcode plus address field
  localparam int unsigned BIT_CNT_W     = 4;

  // reference clock and programming time
  localparam int unsigned REF_PERIOD_NS = 100;
  localparam int unsigned PROG_CNT_W    = 24;

  // opcodes
  localparam logic [1:0]  OP_SPECIAL    = 2'h0;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [1:0]  OP_ERASE      = 2'h3;

  // top address bits under the special opcode
  localparam logic [1:0]  SUB_DISABLE   = 2'h0;
  localparam logic [1:0]  SUB_GLOB_WR   = 2'h1;
  localparam logic [1:0]  SUB_GLOB_ER   = 2'h2;
  localparam logic [1:0]  SUB_ENABLE    = 2'h3;

  // full address patterns of protect clear and protect freeze
  localparam logic [5:0]  PR_CLEAR_ADDR  = 6'h3f;
  localparam logic [5:0]  PR_FREEZE_ADDR = 6'h00;

  // reset values
  localparam logic [15:0] WORD_RST      = 16'hffff;
  localparam logic [5:0]  PTR_RST       = 6'h3f;
  localparam logic        PTR_CLR_RST   = 1'b1;

  // serial-side receiver states
  typedef enum logic [2:0] {
    LS_IDLE,
    LS_HDR,
    LS_DATA,
    LS_READ,
    LS_DONE
  } sep_lstate_type;

  // serial-side shifter; cleared whenever chip select is low
  typedef struct packed {
    sep_lstate_type         st;
    logic [BIT_CNT_W-1:0]   cnt;
    logic [HDR_W-1:0]       hdr;
    logic [WORD_W-1:0]      dat;
    logic                   prog_ok;
    logic                   pre;
    logic [ADDR_W-1:0]      addr;
    logic [WORD_W-1:0]      osr;
    logic                   dout;
  } sep_link_type;

  // serial-side hand-off record; survives chip select going low
  typedef struct packed {
    logic [1:0]             op;
    logic [ADDR_W-1:0]      addr;
    logic [WORD_W-1:0]      data;
    logic                   prog_ok;
    logic                   pre;
    logic                   cmd_tgl;
    logic                   clr_tgl;
  } sep_cmd_type;

  // reference-side state: array, protection and programming timer
  typedef struct packed {
    logic [WORDS-1:0][WORD_W-1:0] mem;
    logic [ADDR_W-1:0]      ptr;
    logic                   ptr_clr;
    logic                   frozen;
    logic                   wen;
    logic                   armed;
    logic                   busy;
    logic                   vis;
    logic [PROG_CNT_W-1:0]  pcnt;
    logic                   cs_s1;
    logic                   cs_s2;
    logic                   tgl_s1;
    logic                   tgl_s2;
    logic                   tgl_seen;
    logic                   clr_s1;
    logic                   clr_s2;
    logic                   clr_seen;
  } sep_core_type;

endpackage : sep_pkg

//--- testbench/sep_core_properties.sv
// pin-level assertions for the serial eeprom command block
`timescale 1ns/1ps
module sep_core_properties #(
  parameter int unsigned PROG_TIME_NS = 2000000
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_clock_pin,
  input wire logic i_chip_select,
  input wire logic i_serial_in_pin,
  input wire logic i_program_enable_pin,
  input wire logic i_protect_select_pin,
  input wire logic o_serial_out,
  input wire logic o_serial_out_en
);
  localparam int PCYC = (PROG_TIME_NS + 99) / 100;
  logic [1:0]  st_r  = 2'd0;  // 0 idle, 1 header, 2 read, 3 other
  logic [3:0]  n_r   = 4'h0;
  logic [1:0]  op_r;
  logic        ps_r;
  logic        dmy_r = 1'b0;
  logic        neg_r;
  logic [23:0] bcnt_r;
  wire         busy_vis = o_serial_out_en && !o_serial_out && st_r != 2'd2;

  // framing tracker; cleared with chip select just like the receiver
  always_ff @(posedge i_serial_clock_pin or negedge i_chip_select)
  begin
    if (!i_chip_select)
    begin
      st_r  <= 2'd0;
      dmy_r <= 1'b0;
    end
    else if (st_r == 2'd0 && i_serial_in_pin)
    begin
      st_r <= 2'd1;
      n_r  <= 4'h0;
      ps_r <= i_protect_select_pin;
    end
    else if (st_r == 2'd1)
    begin
      op_r  <= (n_r < 4'h2) ? {op_r[0], i_serial_in_pin} : op_r;
      n_r   <= (n_r == 4'h7) ? 4'hf : n_r + 4'h1;
      st_r  <= (n_r != 4'h7) ? 2'd1 : (op_r == 2'h2) ? 2'd2 : 2'd3;
      dmy_r <= n_r == 4'h7 && op_r == 2'h2;
    end
    else if (st_r == 2'd2)
    begin
      n_r   <= n_r + 4'h1;
      dmy_r <= 1'b0;
    end
  end

  // output level half a period after each rising edge
  always_ff @(negedge i_serial_clock_pin)
    neg_r <= o_serial_out;

  // length of the busy run seen on the pin; a stuck timer shows up here
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
    if (!i_rst_b)
      bcnt_r <= 24'h0;
    else
      bcnt_r <= busy_vis ? bcnt_r + 24'h1 : 24'h0;

  a_en_needs_cs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_serial_out_en |-> i_chip_select) else $error("output enabled while deselected");
  a_busy_bounded: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    bcnt_r <= PCYC + 1) else $error("busy longer than the programming time");
  a_ready_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_serial_out_en && o_serial_out && st_r != 2'd2 |=> o_serial_out || !o_serial_out_en || st_r == 2'd2)
    else $error("ready fell back to busy");
  a_status_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(st_r == 2'd1) |-> ##[1:4] (!o_serial_out_en || st_r == 2'd2)) else $error("status not cleared");
  a_dummy_zero: assert property (@(negedge i_serial_clock_pin) disable iff (!i_rst_b)
    dmy_r |-> o_serial_out_en && !o_serial_out) else $error("leading zero missing");
  a_read_drives: assert property (@(negedge i_serial_clock_pin) disable iff (!i_rst_b)
    st_r == 2'd2 |-> o_serial_out_en) else $error("read stream not driven");
  a_rise_only: assert property (@(posedge i_serial_clock_pin) disable iff (!i_rst_b)
    st_r == 2'd2 |-> o_serial_out == neg_r) else $error("output moved on a falling edge");
  a_ptr_tail: assert property (@(negedge i_serial_clock_pin) disable iff (!i_rst_b)
    st_r == 2'd2 && ps_r && !dmy_r && n_r > 4'h5 |-> !o_serial_out) else $error("pointer tail not zero");
endmodule : sep_core_properties

bind sep_core sep_core_properties #(.PROG_TIME_NS(PROG_TIME_NS)) u_sep_core_properties (
  .i_ref_clk, .i_rst_b, .i_serial_clock_pin, .i_chip_select, .i_serial_in_pin,
  .i_program_enable_pin, .i_protect_select_pin, .o_serial_out, .o_serial_out_en
);

//--- testbench/sep_host_model.sv
// host model: drives the serial pins and hands back read words and status
`timescale 1ns/1ps
module sep_host_model (
  input  wire logic   i_dout,
  input  wire logic   i_dout_en,
  output logic        o_serial_clock,
  output logic        o_chip_select,
  output logic        o_serial_in,
  output logic        o_program_enable,
  output logic        o_protect_select,
  output logic [15:0] o_res,
  output logic        o_res_tgl
);
  import sep_pkg::*;
  logic lclk = 1'b0;
  logic run  = 1'b0;

  // 6 ns link clock, off phase; the pin only sees it inside frames
  initial
  begin
    o_chip_select = 1'b0;
    o_serial_in = 1'b0;
    o_program_enable = 1'b0;
    o_protect_select = 1'b0;
    o_res = 16'h0;
    o_res_tgl = 1'b0;
    #1.3;
    forever #3 lclk = ~lclk;
  end
  assign o_serial_clock = lclk & run;

  // start bit, opcode, address, then data only where the command has it
  task send(input logic ps, input logic pg, input logic [8:0] h, input logic [15:0] d);
    logic [24:0] f;
    int          n;
    f = {h, d};
    n = (!ps && (h[7:6] == OP_WRITE || (h[7:6] == OP_SPECIAL && h[5:4] == SUB_GLOB_WR))) ? 25 : 9;
    @(negedge lclk);
    o_chip_select <= 1'b1;
    o_protect_select <= ps;
    o_program_enable <= pg;
    o_serial_in <= f[24];
    run <= 1'b1;
    for (int i = 1; i < n; i++)
    begin
      @(negedge lclk);
      o_serial_in <= f[24-i];
    end
    @(negedge lclk);
    run <= 1'b0;
    o_chip_select <= 1'b0;
    o_serial_in <= ~o_serial_in;
    #600;
  endtask : send

  // two words, sampled half a period after each rising edge
  task rd(input logic ps, input logic [5:0] a);
    logic [8:0]  h;
    logic [15:0] w;
    h = {1'b1, OP_READ, a};
    @(negedge lclk);
    o_chip_select <= 1'b1;
    o_protect_select <= ps;
    o_serial_in <= h[8];
    run <= 1'b1;
    for (int i = 1; i <= 41; i++)
    begin
      @(negedge lclk);
      if (i < 9)
        o_serial_in <= h[8-i];
      w = {w[14:0], i_dout};
      if (i >= 10 && (i - 9) % 16 == 0)
      begin
        o_res <= w;
        o_res_tgl <= ~o_res_tgl;
      end
    end
    run <= 1'b0;
    o_chip_select <= 1'b0;
    o_serial_in <= ~h[0];
    #600;
  endtask : rd

  // shown/busy/ready/after-clear flags; a start bit clocked with chip select high clears
  task status();
    logic e0;
    logic b0;
    logic rdy;
    @(negedge lclk);
    o_chip_select <= 1'b1;
    #200;
    e0 = i_dout_en;
    b0 = i_dout;
    for (int k = 0; k < 40 && i_dout !== 1'b1; k++)
      #100;
    rdy = i_dout_en & i_dout;
    @(negedge lclk);
    o_serial_in <= 1'b1;
    run <= 1'b1;
    @(negedge lclk);
    run <= 1'b0;
    #400;
    o_res <= {12'h0, e0, e0 & ~b0, rdy, i_dout_en};
    o_res_tgl <= ~o_res_tgl;
    @(negedge lclk);
    o_chip_select <= 1'b0;
    o_serial_in <= 1'b0;
    #600;
  endtask : status
endmodule : sep_host_model

//--- testbench/tb_sep_core.sv
// self-checking bench for the serial eeprom command block
`timescale 1ns/1ps
module tb_sep_core;
  import sep_pkg::*;
  localparam logic [15:0] OK = 16'h000e;  // shown, busy, ready, cleared
  localparam logic [15:0] NO = 16'h0000;  // refused: nothing shown
  logic        i_ref_clk = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic        i_serial_clock_pin, i_chip_select, i_serial_in_pin;
  logic        i_program_enable_pin, i_protect_select_pin, o_serial_out, o_serial_out_en, res_tgl;
  logic [15:0] res, d0, d1, d2;
  logic [15:0] expq[$];
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc       = 0;

  sep_core #(.PROG_TIME_NS(2000)) u_sep_core (.i_ref_clk, .i_rst_b, .i_serial_clock_pin, .i_chip_select,
    .i_serial_in_pin, .i_program_enable_pin, .i_protect_select_pin, .o_serial_out, .o_serial_out_en);
  sep_host_model u_sep_host_model (.i_dout(o_serial_out), .i_dout_en(o_serial_out_en),
    .o_serial_clock(i_serial_clock_pin), .o_chip_select(i_chip_select), .o_serial_in(i_serial_in_pin),
    .o_program_enable(i_program_enable_pin), .o_protect_select(i_protect_select_pin),
    .o_res(res), .o_res_tgl(res_tgl));

  initial forever #50 i_ref_clk = ~i_ref_clk;

  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task results();
    // a note never answered means a result went missing
    if (expq.size() != 0)
      error_cnt++;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task cmd(input logic ps, input logic pg, input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    u_sep_host_model.send(ps, pg, {1'b1, op, a}, d);
  endtask : cmd

  task st(input logic [15:0] e);
    expq.push_back(e);
    u_sep_host_model.status();
  endtask : st

  task rd(input logic ps, input logic [5:0] a, input logic [15:0] e0, input logic [15:0] e1);
    expq.push_back(e0);
    expq.push_back(e1);
    u_sep_host_model.rd(ps, a);
  endtask : rd

  // each result from the host retires the oldest note
  always @(res_tgl)
    if ($time > 0)
      chk("host result", res, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);

  // a hang counts as a mismatch
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      results();
    end
  end

  initial
  begin
    void'($urandom(61031));
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    cmd(0, 1, OP_WRITE, 6'h05, d0);
    st(NO);
    rd(0, 6'h05, 16'hffff, 16'hffff);
    $display("test power-up done");
    cmd(0, 1, OP_SPECIAL, {SUB_ENABLE, 4'h0}, 0);
    cmd(0, 1, OP_WRITE, 6'h05, d0);
    st(OK);
    cmd(0, 0, OP_WRITE, 6'h06, d1);
    st(NO);
    rd(0, 6'h05, d0, 16'hffff);
    cmd(0, 1, OP_ERASE, 6'h05, 0);
    st(OK);
    rd(0, 6'h05, 16'hffff, 16'hffff);
    cmd(0, 1, OP_SPECIAL, {SUB_GLOB_WR, 4'h0}, d2);
    st(OK);
    cmd(0, 1, OP_WRITE, 6'h00, d0);
    st(OK);
    rd(0, 6'h3f, d2, d0);
    $display("test word ops done");
    cmd(1, 1, OP_SPECIAL, {SUB_ENABLE, 4'h0}, 0);
    cmd(1, 1, OP_WRITE, 6'h08, 0);
    st(OK);
    rd(1, 6'h00, 16'h2000, 16'h2000);
    cmd(0, 1, OP_WRITE, 6'h08, d1);
    st(NO);
    cmd(0, 1, OP_ERASE, 6'h08, 0);
    st(NO);
    cmd(0, 1, OP_WRITE, 6'h07, d1);
    st(OK);
    cmd(0, 1, OP_SPECIAL, {SUB_GLOB_ER, 4'h0}, 0);
    st(OK);
    rd(0, 6'h07, 16'hffff, d2);
    cmd(0, 1, OP_SPECIAL, {SUB_GLOB_WR, 4'h0}, d1);
    st(NO);
    rd(0, 6'h08, d2, d2);
    $display("test protect done");
    cmd(1, 1, OP_SPECIAL, {SUB_ENABLE, 4'h0}, 0);
    cmd(1, 1, OP_ERASE, PR_CLEAR_ADDR, 0);
    st(OK);
    cmd(1, 1, OP_SPECIAL, {SUB_ENABLE, 4'h0}, 0);
    cmd(1, 1, OP_SPECIAL, PR_FREEZE_ADDR, 0);
    st(OK);
    cmd(1, 1, OP_SPECIAL, {SUB_ENABLE, 4'h0}, 0);
    cmd(1, 1, OP_WRITE, 6'h04, 0);
    st(NO);
    rd(1, 6'h00, 16'hfc00, 16'hfc00);
    $display("test freeze done");
    cmd(0, 0, OP_SPECIAL, {SUB_DISABLE, 4'h0}, 0);
    cmd(0, 1, OP_WRITE, 6'h01, d0);
    st(NO);
    rd(0, 6'h01, 16'hffff, 16'hffff);
    $display("test disable done");
    #1000;
    results();
  end
endmodule : tb_sep_core
